/* File: src/sixteen_bit_capture_compare_timer.sv */
// 16-bit timer with three capture/compare channels
`timescale 1ns/10ps
// Summary of operation
// - Counter steps once per tick divided by prescaler 1, 8, 32 or 128.
// - Tick rate only gates the timer; system clock never changes.
// - Reading count low byte latches high byte; software reads low first.
// - Any write to count low byte clears the whole counter.
// - Nonzero mode runs the counter; mode 00 holds the present count.
// - Free-running counts 0x0000 to 0xFFFF then reloads zero.
// - Free-running sets wrap flag when count reaches 0xFFFF.
// - Modulo counts zero to channel 0 period, then reloads zero.
// - Modulo sets wrap flag when count reaches channel 0 period.
// - Up/down counts up to channel 0 period, down to zero, repeats.
// - Up/down sets wrap flag whenever down count reaches zero.
// - Wrap raises CPU flag if masked in; request also needs enable.
// - Three independent channels, each with one pin.
// - Capture copies count on selected pin edge while running.
// - Capture pins are synchronised; pulses must exceed one clock.
// - Capture sets channel flag; mask gates CPU flag, enable gates request.
// - Source select routes enabled radio events to capture.
// - Compare match sets, clears or toggles the driven pin.
// - Compare pins change only from flip-flops, glitch free.
// - Compare low byte is buffered until high byte is written.
// - Compare match sets channel flag (channel 0 in up/down: when down count reaches zero), gated to CPU flag and request.
module sixteen_bit_capture_compare_timer
    import timer_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire timer_ctl_t timerCtl,
    input wire chan_ctl_t [NUM_CH-1:0] chanCtl,
    input wire logic wrapIntMask,
    input wire logic timerIntEnable,
    input wire logic countLowRead,
    input wire logic countLowWrite,
    input wire logic [NUM_CH-1:0] ccLowWrite,
    input wire logic [NUM_CH-1:0] ccHighWrite,
    input wire logic [BYTE_W-1:0] writeData,
    input wire logic wrapFlagClear,
    input wire logic [NUM_CH-1:0] chanFlagClear,
    input wire logic cpuFlagClear,
    input wire logic [NUM_CH-1:0] chanPinIn,
    input wire logic [RADIO_W-1:0] radioEvent,
    input wire logic [RADIO_W-1:0] radioEventMask,
    output logic [CNT_W-1:0] count,
    output logic [BYTE_W-1:0] countHighByte,
    output logic [NUM_CH-1:0][CNT_W-1:0] ccValue,
    output logic wrapFlag,
    output logic [NUM_CH-1:0] chanFlag,
    output logic cpuTimerFlag,
    output logic timerIrq,
    output logic [NUM_CH-1:0] chanPinOut,
    output logic [NUM_CH-1:0] chanPinOe
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] cntNxt;
    logic [BYTE_W-1:0] countHigh_r;
    logic [NUM_CH-1:0][CNT_W-1:0] ccReg_r;
    logic [NUM_CH-1:0][BYTE_W-1:0] ccLowBuf_r;
    dir_t dir_r;
    dir_t dirNxt;
    logic [TICK_W-1:0] tickCnt_r;
    logic [TICK_W-1:0] preCnt_r;
    logic [TICK_W-1:0] tickMask;
    logic [TICK_W-1:0] preMask;
    logic tick;
    logic divTick;
    logic running;
    logic step;
    logic wrapEvt;
    logic wrapFlag_r;
    logic [NUM_CH-1:0] chanFlag_r;
    logic cpuFlag_r;
    logic irq_r;
    logic [NUM_CH-1:0] pinSync1_r;
    logic [NUM_CH-1:0] pinSync2_r;
    logic [NUM_CH-1:0] pinPrev_r;
    logic [NUM_CH-1:0] pinOut_r;
    logic [NUM_CH-1:0] pinOe_r;
    logic [NUM_CH-1:0] edgeHit;
    logic [NUM_CH-1:0] capEvt;
    logic [NUM_CH-1:0] cmpEvt;
    logic [NUM_CH-1:0] chanEvt;
    logic [NUM_CH-1:0] intMaskVec;
    logic radioHit;
    logic cpuSet;
    logic [CNT_W-1:0] period;

    assign period = ccReg_r[0];
    assign running = (timerCtl.mode != MODE_STOP);

    // ************************************************************
    // Tick enable and prescaler
    // ************************************************************
    always_comb
    begin
        tickMask = ~(TICK_ALL << timerCtl.tickRate);
        tick = ((tickCnt_r & tickMask) == tickMask);
        case (timerCtl.prescale)
            DIV_1: preMask = PRE_MASK_1;
            DIV_8: preMask = PRE_MASK_8;
            DIV_32: preMask = PRE_MASK_32;
            DIV_128: preMask = PRE_MASK_128;
            default: preMask = PRE_MASK_1;
        endcase
        divTick = tick && ((preCnt_r & preMask) == preMask);
        step = running && divTick;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tickCnt_r <= TICK_ZERO;
        end
        else
        begin
            tickCnt_r <= tickCnt_r + TICK_ONE;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            preCnt_r <= TICK_ZERO;
        end
        else if (running && tick)
        begin
            preCnt_r <= preCnt_r + TICK_ONE;
        end
    end

    // ************************************************************
    // Counter next state
    // ************************************************************
    always_comb
    begin
        cntNxt = count_r;
        dirNxt = dir_r;
        wrapEvt = 1'b0;
        if (countLowWrite)
        begin
            cntNxt = CNT_ZERO;
            dirNxt = DIR_UP;
        end
        else if (step)
        begin
            case (timerCtl.mode)
                MODE_FREE:
                begin
                    cntNxt = count_r + CNT_ONE;
                    wrapEvt = (cntNxt == CNT_TOP);
                end
                MODE_MOD:
                begin
                    if (count_r >= period)
                    begin
                        cntNxt = CNT_ZERO;
                    end
                    else
                    begin
                        cntNxt = count_r + CNT_ONE;
                    end
                    wrapEvt = (cntNxt == period);
                end
                MODE_UPDN:
                begin
                    case (dir_r)
                        DIR_UP:
                        begin
                            if (count_r < period)
                            begin
                                cntNxt = count_r + CNT_ONE;
                            end
                            else if (count_r != CNT_ZERO)
                            begin
                                cntNxt = count_r - CNT_ONE;
                                dirNxt = DIR_DOWN;
                            end
                        end
                        DIR_DOWN:
                        begin
                            if (count_r == CNT_ZERO)
                            begin
                                dirNxt = DIR_UP;
                            end
                            else
                            begin
                                cntNxt = count_r - CNT_ONE;
                                if (cntNxt == CNT_ZERO)
                                begin
                                    dirNxt = DIR_UP;
                                    wrapEvt = 1'b1;
                                end
                            end
                        end
                        default: dirNxt = DIR_UP;
                    endcase
                end
                default: cntNxt = count_r;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            count_r <= CNT_ZERO;
            dir_r <= DIR_UP;
        end
        else
        begin
            count_r <= cntNxt;
            dir_r <= dirNxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            countHigh_r <= BYTE_ZERO;
        end
        else if (countLowRead)
        begin
            countHigh_r <= count_r[CNT_W-1:BYTE_W];
        end
    end

    // ************************************************************
    // Channel inputs
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pinSync1_r <= '0;
            pinSync2_r <= '0;
            pinPrev_r <= '0;
        end
        else
        begin
            pinSync1_r <= chanPinIn;
            pinSync2_r <= pinSync1_r;
            pinPrev_r <= pinSync2_r;
        end
    end

    // ************************************************************
    // Channel events
    // ************************************************************
    always_comb
    begin
        radioHit = |(radioEvent & radioEventMask);
        for (int i = 0; i < NUM_CH; i++)
        begin
            case (chanCtl[i].capEdge)
                EDGE_RISE: edgeHit[i] = pinSync2_r[i] && !pinPrev_r[i];
                EDGE_FALL: edgeHit[i] = !pinSync2_r[i] && pinPrev_r[i];
                EDGE_ANY: edgeHit[i] = pinSync2_r[i] != pinPrev_r[i];
                EDGE_NONE: edgeHit[i] = 1'b0;
                default: edgeHit[i] = 1'b0;
            endcase
            capEvt[i] = running && !chanCtl[i].compareMode
                && (chanCtl[i].srcRadio ? radioHit : edgeHit[i]);
            cmpEvt[i] = step && !countLowWrite && chanCtl[i].compareMode
                && (cntNxt == ccReg_r[i]);
            chanEvt[i] = capEvt[i] || cmpEvt[i];
            intMaskVec[i] = chanCtl[i].intMask;
        end
        if (chanCtl[0].compareMode && timerCtl.mode == MODE_UPDN)
        begin
            chanEvt[0] = wrapEvt;
        end
    end

    // ************************************************************
    // Capture/compare registers
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                ccReg_r[i] <= CC_RESET;
                ccLowBuf_r[i] <= BYTE_ZERO;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (ccLowWrite[i])
                begin
                    ccLowBuf_r[i] <= writeData;
                end
                if (capEvt[i])
                begin
                    ccReg_r[i] <= count_r;
                end
                else if (ccHighWrite[i])
                begin
                    ccReg_r[i] <= {writeData, ccLowBuf_r[i]};
                end
            end
        end
    end

    // ************************************************************
    // Compare outputs
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pinOut_r <= '0;
            pinOe_r <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                pinOe_r[i] <= running && chanCtl[i].compareMode;
                if (cmpEvt[i])
                begin
                    case (chanCtl[i].action)
                        ACT_SET: pinOut_r[i] <= 1'b1;
                        ACT_CLEAR: pinOut_r[i] <= 1'b0;
                        ACT_TOGGLE: pinOut_r[i] <= !pinOut_r[i];
                        default: pinOut_r[i] <= pinOut_r[i];
                    endcase
                end
            end
        end
    end

    // ************************************************************
    // Event flags
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wrapFlag_r <= 1'b0;
        end
        else
        begin
            wrapFlag_r <= wrapEvt || (wrapFlag_r && !wrapFlagClear);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            chanFlag_r <= '0;
        end
        else
        begin
            chanFlag_r <= chanEvt | (chanFlag_r & ~chanFlagClear);
        end
    end

    // ************************************************************
    // CPU flag and request
    // ************************************************************
    always_comb
    begin
        cpuSet = (wrapFlag_r && wrapIntMask)
            || |(chanFlag_r & intMaskVec);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cpuFlag_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            cpuFlag_r <= cpuSet || (cpuFlag_r && !cpuFlagClear);
            irq_r <= cpuFlag_r && timerIntEnable;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign count = count_r;
    assign countHighByte = countHigh_r;
    assign ccValue = ccReg_r;
    assign wrapFlag = wrapFlag_r;
    assign chanFlag = chanFlag_r;
    assign cpuTimerFlag = cpuFlag_r;
    assign timerIrq = irq_r;
    assign chanPinOut = pinOut_r;
    assign chanPinOe = pinOe_r;

endmodule

/* File: src/timer_pkg.sv */
// Constants and types shared by the capture/compare timer
package timer_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int NUM_CH = 3;
    localparam int TICK_W = 7;
    localparam int RADIO_W = 8;

    // ************************************************************
    // Counter values
    // ************************************************************
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_TOP = 16'hffff;
    localparam logic [CNT_W-1:0] CC_RESET = 16'h0000;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

    // ************************************************************
    // Tick divider and prescaler
    // ************************************************************
    localparam logic [TICK_W-1:0] TICK_ONE = 7'h01;
    localparam logic [TICK_W-1:0] TICK_ZERO = 7'h00;
    localparam logic [TICK_W-1:0] TICK_ALL = 7'h7f;
    localparam logic [1:0] DIV_1 = 2'h0;
    localparam logic [1:0] DIV_8 = 2'h1;
    localparam logic [1:0] DIV_32 = 2'h2;
    localparam logic [1:0] DIV_128 = 2'h3;
    localparam logic [TICK_W-1:0] PRE_MASK_1 = 7'h00;
    localparam logic [TICK_W-1:0] PRE_MASK_8 = 7'h07;
    localparam logic [TICK_W-1:0] PRE_MASK_32 = 7'h1f;
    localparam logic [TICK_W-1:0] PRE_MASK_128 = 7'h7f;

    // ************************************************************
    // Mode, edge and action codes
    // ************************************************************
    localparam logic [1:0] MODE_STOP = 2'h0;
    localparam logic [1:0] MODE_FREE = 2'h1;
    localparam logic [1:0] MODE_MOD = 2'h2;
    localparam logic [1:0] MODE_UPDN = 2'h3;
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_ANY = 2'h3;
    localparam logic [2:0] ACT_SET = 3'h0;
    localparam logic [2:0] ACT_CLEAR = 3'h1;
    localparam logic [2:0] ACT_TOGGLE = 3'h2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        DIR_UP = 2'b01,
        DIR_DOWN = 2'b10
    } dir_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] prescale;
        logic [2:0] tickRate;
    } timer_ctl_t;

    typedef struct packed {
        logic compareMode;
        logic [1:0] capEdge;
        logic [2:0] action;
        logic srcRadio;
        logic intMask;
    } chan_ctl_t;

endpackage

/* File: tb/timer_props.sv */
// Port assertions for the capture/compare timer
`timescale 1ns/10ps
module timer_props
    import timer_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire timer_ctl_t timerCtl,
    input wire chan_ctl_t [NUM_CH-1:0] chanCtl,
    input wire logic wrapIntMask,
    input wire logic timerIntEnable,
    input wire logic countLowRead,
    input wire logic countLowWrite,
    input wire logic [NUM_CH-1:0] ccLowWrite,
    input wire logic [NUM_CH-1:0] ccHighWrite,
    input wire logic [BYTE_W-1:0] writeData,
    input wire logic wrapFlagClear,
    input wire logic [NUM_CH-1:0] chanPinIn,
    input wire logic [CNT_W-1:0] count,
    input wire logic [BYTE_W-1:0] countHighByte,
    input wire logic [NUM_CH-1:0][CNT_W-1:0] ccValue,
    input wire logic wrapFlag,
    input wire logic [NUM_CH-1:0] chanFlag,
    input wire logic cpuTimerFlag,
    input wire logic timerIrq,
    input wire logic [NUM_CH-1:0] chanPinOut,
    input wire logic [NUM_CH-1:0] chanPinOe
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic [BYTE_W-1:0] lowBuf_r;
    logic [NUM_CH-1:0] chMask;
    logic fast;
    assign chMask = {chanCtl[2].intMask, chanCtl[1].intMask, chanCtl[0].intMask};
    assign fast = timerCtl.tickRate == 3'h0 && timerCtl.prescale == DIV_1 && !countLowWrite;
    always_ff @(posedge clk)
    begin
        if (ccLowWrite[1])
        begin
            lowBuf_r <= writeData;
        end
    end
    property p_stop_hold;
        timerCtl.mode == MODE_STOP && !countLowWrite |=> $stable(count);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("count moved while stopped");
    property p_clear;
        countLowWrite |=> count == CNT_ZERO;
    endproperty
    a_clear: assert property (p_clear) else $error("count not cleared");
    property p_free_step;
        timerCtl.mode == MODE_FREE && fast |=> count == $past(count) + CNT_ONE;
    endproperty
    a_free_step: assert property (p_free_step) else $error("free step wrong");
    property p_wrap_free;
        timerCtl.mode == MODE_FREE && fast && count == 16'hfffe && !wrapFlagClear
            |=> wrapFlag && count == CNT_TOP;
    endproperty
    a_wrap_free: assert property (p_wrap_free) else $error("no wrap at top");
    property p_mod_wrap;
        timerCtl.mode == MODE_MOD && fast && count + CNT_ONE == ccValue[0] && !wrapFlagClear
            |=> wrapFlag ##1 count == CNT_ZERO;
    endproperty
    a_mod_wrap: assert property (p_mod_wrap) else $error("modulo wrap wrong");
    property p_updn_wrap;
        timerCtl.mode == MODE_UPDN && fast && count == CNT_ONE && $past(count) == 16'h0002
            && !wrapFlagClear |=> count == CNT_ZERO && wrapFlag;
    endproperty
    a_updn_wrap: assert property (p_updn_wrap) else $error("down wrap wrong");
    property p_cpu_cause;
        $rose(cpuTimerFlag) |-> $past(wrapFlag && wrapIntMask || (chanFlag & chMask) != '0);
    endproperty
    a_cpu_cause: assert property (p_cpu_cause) else $error("cpu flag unmasked");
    property p_irq;
        timerIrq == $past(cpuTimerFlag && timerIntEnable);
    endproperty
    a_irq: assert property (p_irq) else $error("request wrong");
    property p_read;
        countLowRead |=> countHighByte == $past(count[15:8]);
    endproperty
    a_read: assert property (p_read) else $error("high byte not latched");
    property p_cc_write;
        ccHighWrite[1] |=> ccValue[1] == {$past(writeData), $past(lowBuf_r)};
    endproperty
    a_cc_write: assert property (p_cc_write) else $error("compare write wrong");
    property p_capture;
        $rose(chanPinIn[2]) && !chanCtl[2].compareMode && !chanCtl[2].srcRadio
            && chanCtl[2].capEdge == EDGE_RISE && timerCtl.mode != MODE_STOP
            |-> ##[1:4] chanFlag[2];
    endproperty
    a_capture: assert property (p_capture) else $error("no capture");
    property p_compare;
        $changed(count) && !$past(countLowWrite) && count == ccValue[1]
            && chanCtl[1].compareMode && chanCtl[1].action == ACT_SET
            |-> chanFlag[1] ##1 chanPinOut[1];
    endproperty
    a_compare: assert property (p_compare) else $error("compare set wrong");
    property p_oe;
        chanCtl[1].compareMode && timerCtl.mode != MODE_STOP |=> chanPinOe[1];
    endproperty
    a_oe: assert property (p_oe) else $error("pin not driven");
    c_wrap: cover property ($rose(wrapFlag));
    c_cap: cover property ($rose(chanFlag[2]));
    c_irq: cover property ($rose(timerIrq));
endmodule
bind sixteen_bit_capture_compare_timer timer_props u_props (.clk, .rst_n, .timerCtl,
    .chanCtl, .wrapIntMask, .timerIntEnable, .countLowRead, .countLowWrite, .ccLowWrite,
    .ccHighWrite, .writeData, .wrapFlagClear, .chanPinIn, .count, .countHighByte, .ccValue,
    .wrapFlag, .chanFlag, .cpuTimerFlag, .timerIrq, .chanPinOut, .chanPinOe);

/* File: tb/pin_event_source.sv */
// Model of the channel pins and radio event source
`timescale 1ns/10ps
module pin_event_source
    import timer_pkg::*;
(
    input wire logic clk,
    output logic [NUM_CH-1:0] pinLevel,
    output logic [RADIO_W-1:0] radioPulse
);
    // ****************
    // Drivers
    // ****************
    initial {pinLevel, radioPulse} = '0;
    task automatic pin_pulse(input int ch, input int len);
        pinLevel[ch] = 1'b1;
        repeat (len) @(posedge clk);
        #1;
        pinLevel[ch] = 1'b0;
    endtask
    task automatic radio_pulse(input int ev);
        radioPulse[ev] = 1'b1;
        @(posedge clk);
        #1;
        radioPulse[ev] = 1'b0;
    endtask
endmodule

/* File: tb/tb_sixteen_bit_capture_compare_timer.sv */
// Self-checking bench for the capture/compare timer
`timescale 1ns/10ps
module tb_sixteen_bit_capture_compare_timer
    import timer_pkg::*;
;
    // ****************
    // Bench
    // ****************
    logic clk, rst_n, wrapIntMask, timerIntEnable, countLowRead, countLowWrite;
    logic wrapFlagClear, cpuFlagClear, wrapFlag, cpuTimerFlag, timerIrq;
    timer_ctl_t timerCtl;
    chan_ctl_t [NUM_CH-1:0] chanCtl;
    logic [NUM_CH-1:0] ccLowWrite, ccHighWrite, chanFlagClear, chanPinIn;
    logic [NUM_CH-1:0] chanFlag, chanPinOut, chanPinOe;
    logic [BYTE_W-1:0] writeData, countHighByte;
    logic [RADIO_W-1:0] radioEvent, radioEventMask;
    logic [CNT_W-1:0] count, v;
    logic [NUM_CH-1:0][CNT_W-1:0] ccValue;
    int num_errors = 0, samples_checked = 0;
    int divs[5] = '{1, 8, 32, 128, 8};
    logic [2:0] acts[3] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE};
    logic pinExp[3] = '{1'b1, 1'b0, 1'b1};
    sixteen_bit_capture_compare_timer DUT (.clk, .rst_n, .timerCtl, .chanCtl, .wrapIntMask,
        .timerIntEnable, .countLowRead, .countLowWrite, .ccLowWrite, .ccHighWrite, .writeData,
        .wrapFlagClear, .chanFlagClear, .cpuFlagClear, .chanPinIn, .radioEvent, .radioEventMask,
        .count, .countHighByte, .ccValue, .wrapFlag, .chanFlag, .cpuTimerFlag, .timerIrq,
        .chanPinOut, .chanPinOe);
    pin_event_source src (.clk(clk), .pinLevel(chanPinIn), .radioPulse(radioEvent));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic conclude();
        if (num_errors == 0 && samples_checked > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check_val(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
        end
    endtask
    task automatic timeout();
        num_errors++;
        $display("unexpected at %0t: wait ran out", $time);
        conclude();
    endtask
    task automatic wait_count(input logic [CNT_W-1:0] want);
        int n;
        for (n = 0; n < 70000 && count !== want; n++)
        begin
            step(1);
        end
        if (n == 70000)
        begin
            timeout();
        end
    endtask
    task automatic wait_flag(input int ch);
        int n;
        for (n = 0; n < 100 && chanFlag[ch] !== 1'b1; n++)
        begin
            step(1);
        end
        if (n == 100)
        begin
            timeout();
        end
    endtask
    task automatic run(input logic [1:0] m, input logic [1:0] p, input logic [2:0] r);
        timerCtl = {m, p, r};
    endtask
    task automatic clear_count();
        countLowWrite = 1'b1;
        step(1);
        countLowWrite = 1'b0;
    endtask
    task automatic wr_cc(input int ch, input logic [CNT_W-1:0] val);
        logic [CNT_W-1:0] prev;
        prev = ccValue[ch];
        ccLowWrite[ch] = 1'b1;
        writeData = val[7:0];
        step(1);
        ccLowWrite[ch] = 1'b0;
        check_val(ccValue[ch], prev);
        ccHighWrite[ch] = 1'b1;
        writeData = val[15:8];
        step(1);
        ccHighWrite[ch] = 1'b0;
        check_val(ccValue[ch], val);
    endtask
    initial
    begin
        rst_n = 1'b0;
        {timerCtl, chanCtl, wrapIntMask, timerIntEnable, countLowRead, countLowWrite} = '0;
        {ccLowWrite, ccHighWrite, writeData, wrapFlagClear, chanFlagClear, cpuFlagClear} = '0;
        radioEventMask = '0;
        step(16);
        rst_n = 1'b1;
        check_val(count, CNT_ZERO);
        check_val(ccValue[0] | ccValue[1] | ccValue[2], CC_RESET);
        check_val(16'({wrapFlag, chanFlag, cpuTimerFlag, timerIrq, chanPinOe}), CNT_ZERO);
        for (int i = 0; i < 5; i++)
        begin
            clear_count();
            run(MODE_FREE, i < 4 ? 2'(i) : DIV_1, i < 4 ? 3'h0 : 3'h3);
            wait_count(CNT_ONE);
            step(8 * divs[i]);
            check_val(count, 16'h0009);
        end
        run(MODE_STOP, DIV_1, 3'h0);
        v = count;
        step(20);
        check_val(count, v);
        clear_count();
        check_val(count, CNT_ZERO);
        wrapIntMask = 1'b1;
        timerIntEnable = 1'b1;
        run(MODE_FREE, DIV_1, 3'h0);
        wait_count(16'h12ff);
        countLowRead = 1'b1;
        step(1);
        countLowRead = 1'b0;
        check_val(16'(countHighByte), 16'h0012);
        wait_count(CNT_TOP);
        check_bit(wrapFlag, 1'b1);
        step(1);
        check_val(count, CNT_ZERO);
        check_bit(cpuTimerFlag, 1'b1);
        step(1);
        check_bit(timerIrq, 1'b1);
        wrapFlagClear = 1'b1;
        step(1);
        wrapFlagClear = 1'b0;
        cpuFlagClear = 1'b1;
        step(1);
        cpuFlagClear = 1'b0;
        check_bit(cpuTimerFlag, 1'b0);
        step(1);
        check_bit(timerIrq, 1'b0);
        run(MODE_STOP, DIV_1, 3'h0);
        wr_cc(0, 16'h0005);
        clear_count();
        wrapIntMask = 1'b0;
        run(MODE_MOD, DIV_1, 3'h0);
        wait_count(16'h0005);
        check_bit(wrapFlag, 1'b1);
        step(1);
        check_val(count, CNT_ZERO);
        step(1);
        check_bit(cpuTimerFlag, 1'b0);
        run(MODE_STOP, DIV_1, 3'h0);
        clear_count();
        wrapFlagClear = 1'b1;
        step(1);
        wrapFlagClear = 1'b0;
        run(MODE_UPDN, DIV_1, 3'h0);
        for (int i = 1; i < 12; i++)
        begin
            step(1);
            check_val(count, 16'(i <= 5 ? i : (i < 11 ? 10 - i : 1)));
            check_bit(wrapFlag, i >= 10);
        end
        chanCtl[2] = {1'b0, EDGE_RISE, ACT_SET, 1'b0, 1'b1};
        chanCtl[0] = {1'b0, EDGE_NONE, ACT_SET, 1'b1, 1'b0};
        radioEventMask = 8'h01;
        run(MODE_FREE, DIV_1, 3'h0);
        step(5);
        v = count;
        src.pin_pulse(2, 3);
        wait_flag(2);
        check_val(ccValue[2], v + 16'h0002);
        step(1);
        check_bit(cpuTimerFlag, 1'b1);
        chanFlagClear[2] = 1'b1;
        step(1);
        chanFlagClear[2] = 1'b0;
        step(6);
        check_bit(chanFlag[2], 1'b0);
        chanCtl[2].capEdge = EDGE_FALL;
        v = count;
        src.pin_pulse(2, 3);
        wait_flag(2);
        check_val(ccValue[2], v + 16'h0005);
        src.radio_pulse(1);
        step(3);
        check_bit(chanFlag[0], 1'b0);
        v = count;
        src.radio_pulse(0);
        check_val(ccValue[0], v);
        check_bit(chanFlag[0], 1'b1);
        wr_cc(1, 16'h000a);
        for (int i = 0; i < 3; i++)
        begin
            chanCtl[1] = {1'b1, EDGE_NONE, acts[i], 1'b0, 1'b0};
            chanFlagClear[1] = 1'b1;
            countLowWrite = 1'b1;
            step(1);
            chanFlagClear[1] = 1'b0;
            countLowWrite = 1'b0;
            wait_flag(1);
            check_val(count, 16'h000a);
            step(1);
            check_bit(chanPinOut[1], pinExp[i]);
            check_bit(chanPinOe[1], 1'b1);
        end
        conclude();
    end
endmodule
